// ===== shared/puec_pkg.sv
package puec_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CTR = 4;
  localparam int CTR_W = 48;
  localparam int EVT_W = 8;
  localparam int TID_W = 3;
  localparam int THR_N = 8;
  localparam int ADDR_W = 8;

  // ****************************************
  // Event codes
  // ****************************************
  localparam logic [7:0] EVT_UNIT_CYCLE = 8'h00;
  localparam logic [7:0] EVT_PROCHOT_INT = 8'h09;
  localparam logic [7:0] EVT_PROCHOT_EXT = 8'h0A;
  localparam logic [7:0] EVT_PKG_ACTIVE = 8'h2A;
  localparam logic [7:0] EVT_PKG_C2E = 8'h2B;
  localparam logic [7:0] EVT_PKG_C3 = 8'h2C;
  localparam logic [7:0] EVT_PKG_C6 = 8'h2D;
  localparam logic [7:0] EVT_MEM_SHED = 8'h2F;
  localparam logic [7:0] EVT_TOTAL_TRANS = 8'h72;
  localparam logic [7:0] EVT_FREQ_CHANGE = 8'h74;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTL_BASE = 8'h00;
  localparam logic [7:0] OFS_CNT_BASE = 8'h10;
  localparam logic [7:0] OFS_CNT_END = 8'h2F;
  localparam logic [7:0] OFS_FILTER = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTL_EVT_LSB = 0;
  localparam int CTL_CLEAR_BIT = 17;
  localparam int CTL_EDGE_BIT = 18;
  localparam int CTL_EN_BIT = 22;
  localparam int CTL_INV_BIT = 23;
  localparam int FILT_TID_LSB = 0;
  localparam int FILT_EN_BIT = 8;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [31:0] FILT_RST = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PKG_C0 = 2'h0,
    PKG_C2E = 2'h1,
    PKG_C3 = 2'h2,
    PKG_C6 = 2'h3
  } puec_cstate_type;

  typedef struct packed {
    logic freq_changing;
    logic mem_phase_shed;
    logic prochot_ext;
    logic prochot_int;
    puec_cstate_type pkg_cstate;
    logic pkg_settled;
    logic [THR_N-1:0] thread_mask;
  } puec_cond_type;

  typedef struct packed {
    logic inv;
    logic en;
    logic edge_det;
    logic [EVT_W-1:0] evt;
  } puec_ctl_type;

  typedef struct packed {
    logic en;
    logic [TID_W-1:0] tid;
  } puec_filt_type;

endpackage

// ===== src/puec_event_select.sv
`timescale 1ns/1ps
module puec_event_select (
  // Conditions
  input wire puec_pkg::puec_cond_type i_cond,
  input wire logic i_core_trans_any,
  // Selection
  input wire logic [puec_pkg::EVT_W-1:0] i_evt,
  input wire puec_pkg::puec_filt_type i_filt,
  // Result
  output logic o_hit,
  output logic o_defined
);

  // ****************************************
  // Condition mux
  // ****************************************
  logic raw;
  logic thr_ok;
  logic filterable;

  always_comb begin
    raw = 1'b0;
    o_defined = 1'b1;
    filterable = 1'b1;
    unique case (i_evt)
      puec_pkg::EVT_UNIT_CYCLE: begin
        raw = 1'b1;
        filterable = 1'b0;
      end
      puec_pkg::EVT_FREQ_CHANGE: begin
        raw = i_cond.freq_changing;
        filterable = 1'b0;
      end
      puec_pkg::EVT_MEM_SHED: raw = i_cond.mem_phase_shed;
      // Residency only counts once the state has settled
      puec_pkg::EVT_PKG_ACTIVE: raw = i_cond.pkg_settled && i_cond.pkg_cstate == puec_pkg::PKG_C0;
      puec_pkg::EVT_PKG_C2E: raw = i_cond.pkg_settled && i_cond.pkg_cstate == puec_pkg::PKG_C2E;
      puec_pkg::EVT_PKG_C3: raw = i_cond.pkg_settled && i_cond.pkg_cstate == puec_pkg::PKG_C3;
      puec_pkg::EVT_PKG_C6: raw = i_cond.pkg_settled && i_cond.pkg_cstate == puec_pkg::PKG_C6;
      puec_pkg::EVT_PROCHOT_EXT: raw = i_cond.prochot_ext;
      puec_pkg::EVT_PROCHOT_INT: raw = i_cond.prochot_int;
      puec_pkg::EVT_TOTAL_TRANS: raw = i_core_trans_any;
      default: o_defined = 1'b0;
    endcase
    thr_ok = !i_filt.en || !filterable || i_cond.thread_mask[i_filt.tid];
    o_hit = raw && thr_ok;
  end

endmodule // puec_event_select

// ===== src/puec_counter.sv
`timescale 1ns/1ps
module puec_counter (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control
  input wire puec_pkg::puec_ctl_type i_ctl,
  input wire logic i_hit,
  input wire logic i_defined,
  // Software access
  input wire logic i_clear,
  input wire logic i_load_lo,
  input wire logic i_load_hi,
  input wire logic [31:0] i_wdata,
  // Count
  output logic [puec_pkg::CTR_W-1:0] o_count
);

  // ****************************************
  // Qualification and count
  // ****************************************
  logic [puec_pkg::CTR_W-1:0] cnt_r;
  logic [puec_pkg::CTR_W-1:0] cnt_nxt;
  logic prev_r;
  logic prev_nxt;
  logic q;
  logic pulse;

  always_comb begin
    q = i_hit ^ i_ctl.inv;
    pulse = i_ctl.edge_det ? (q && !prev_r) : q;
    prev_nxt = q;
    cnt_nxt = cnt_r;
    // A software write wins over a count in the same cycle
    if (i_clear) begin
      cnt_nxt = '0;
    end else if (i_load_lo) begin
      cnt_nxt[31:0] = i_wdata;
    end else if (i_load_hi) begin
      cnt_nxt[puec_pkg::CTR_W-1:32] = i_wdata[puec_pkg::CTR_W-33:0];
    end else if (i_ctl.en && i_defined && pulse) begin
      cnt_nxt = cnt_r + {{(puec_pkg::CTR_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      prev_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign o_count = cnt_r;

endmodule // puec_counter

// ===== src/puec_top.sv
`timescale 1ns/1ps
module puec_top #(
  parameter int NUM_CORES = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [puec_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Power-control conditions
  input wire puec_pkg::puec_cond_type i_cond,
  input wire logic [NUM_CORES-1:0] i_core_trans
);

  // ****************************************
  // Declarations
  // ****************************************
  puec_pkg::puec_ctl_type ctl_r [puec_pkg::NUM_CTR];
  puec_pkg::puec_ctl_type ctl_nxt [puec_pkg::NUM_CTR];
  puec_pkg::puec_filt_type filt_r;
  puec_pkg::puec_filt_type filt_nxt;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;
  logic waitrequest_r;
  logic waitrequest_nxt;

  logic [puec_pkg::CTR_W-1:0] count [puec_pkg::NUM_CTR];
  logic [puec_pkg::NUM_CTR-1:0] hit;
  logic [puec_pkg::NUM_CTR-1:0] defined;
  logic [puec_pkg::NUM_CTR-1:0] clear;
  logic [puec_pkg::NUM_CTR-1:0] load_lo;
  logic [puec_pkg::NUM_CTR-1:0] load_hi;
  logic [31:0] cnt_wdata [puec_pkg::NUM_CTR];

  logic core_trans_any;
  logic acc;
  logic wr_fire;
  logic in_ctl;
  logic in_cnt;
  logic [1:0] ctl_idx;
  logic [1:0] cnt_idx;
  logic cnt_hi;
  logic [puec_pkg::ADDR_W-1:0] cnt_off;
  logic [31:0] rd_mux;
  logic [31:0] wr_word;
  logic [31:0] old_word;
  logic [31:0] status_word;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] ctl_word(input puec_pkg::puec_ctl_type c);
    logic [31:0] w;
    w = puec_pkg::CTL_RST;
    w[puec_pkg::CTL_EVT_LSB +: puec_pkg::EVT_W] = c.evt;
    w[puec_pkg::CTL_EDGE_BIT] = c.edge_det;
    w[puec_pkg::CTL_EN_BIT] = c.en;
    w[puec_pkg::CTL_INV_BIT] = c.inv;
    return w;
  endfunction

  function automatic puec_pkg::puec_ctl_type ctl_unpack(input logic [31:0] w);
    puec_pkg::puec_ctl_type c;
    c.evt = w[puec_pkg::CTL_EVT_LSB +: puec_pkg::EVT_W];
    c.edge_det = w[puec_pkg::CTL_EDGE_BIT];
    c.en = w[puec_pkg::CTL_EN_BIT];
    c.inv = w[puec_pkg::CTL_INV_BIT];
    return c;
  endfunction

  function automatic logic [31:0] filt_word(input puec_pkg::puec_filt_type f);
    logic [31:0] w;
    w = puec_pkg::FILT_RST;
    w[puec_pkg::FILT_TID_LSB +: puec_pkg::TID_W] = f.tid;
    w[puec_pkg::FILT_EN_BIT] = f.en;
    return w;
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    in_ctl = i_address[7:4] == puec_pkg::OFS_CTL_BASE[7:4];
    in_cnt = i_address >= puec_pkg::OFS_CNT_BASE && i_address <= puec_pkg::OFS_CNT_END;
    ctl_idx = i_address[3:2];
    cnt_off = i_address - puec_pkg::OFS_CNT_BASE;
    cnt_idx = cnt_off[4:3];
    cnt_hi = cnt_off[2];
    // The whole core count is folded into one bit so one cycle never adds more than one
    core_trans_any = |i_core_trans;
    status_word = '0;
    status_word[0] = i_cond.freq_changing;
    status_word[1] = i_cond.mem_phase_shed;
    status_word[2] = i_cond.prochot_ext;
    status_word[3] = i_cond.prochot_int;
    status_word[5:4] = i_cond.pkg_cstate;
    status_word[6] = i_cond.pkg_settled;
    status_word[7] = core_trans_any;
    status_word[8 +: puec_pkg::THR_N] = i_cond.thread_mask;
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    old_word = 32'h0000_0000;
    if (in_ctl) begin
      rd_mux = ctl_word(ctl_r[ctl_idx]);
    end else if (in_cnt) begin
      if (cnt_hi) begin
        rd_mux[puec_pkg::CTR_W-33:0] = count[cnt_idx][puec_pkg::CTR_W-1:32];
      end else begin
        rd_mux = count[cnt_idx][31:0];
      end
    end else if (i_address == puec_pkg::OFS_FILTER) begin
      rd_mux = filt_word(filt_r);
    end else if (i_address == puec_pkg::OFS_STATUS) begin
      rd_mux = status_word;
    end
    old_word = rd_mux;
    wr_word = be_merge(old_word, i_writedata, i_byteenable);
  end

  // ****************************************
  // Bus handshake and register writes
  // ****************************************
  // Fixed one wait state: request seen, then answered on the next edge.
  // This costs a cycle but keeps every bus output on a flop.
  always_comb begin
    acc = (i_read || i_write) && waitrequest_r;
    wr_fire = i_write && !waitrequest_r;
    waitrequest_nxt = !acc;
    readdata_nxt = (acc && i_read) ? rd_mux : readdata_r;
    filt_nxt = filt_r;
    clear = '0;
    load_lo = '0;
    load_hi = '0;
    for (int n = 0; n < puec_pkg::NUM_CTR; n++) begin
      ctl_nxt[n] = ctl_r[n];
      cnt_wdata[n] = wr_word;
    end
    if (wr_fire) begin
      if (in_ctl) begin
        ctl_nxt[ctl_idx] = ctl_unpack(wr_word);
        clear[ctl_idx] = wr_word[puec_pkg::CTL_CLEAR_BIT];
      end else if (in_cnt) begin
        if (cnt_hi) begin
          load_hi[cnt_idx] = 1'b1;
        end else begin
          load_lo[cnt_idx] = 1'b1;
        end
      end else if (i_address == puec_pkg::OFS_FILTER) begin
        filt_nxt.tid = wr_word[puec_pkg::FILT_TID_LSB +: puec_pkg::TID_W];
        filt_nxt.en = wr_word[puec_pkg::FILT_EN_BIT];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int n = 0; n < puec_pkg::NUM_CTR; n++) begin
        ctl_r[n] <= '0;
      end
      filt_r <= '0;
      readdata_r <= 32'h0000_0000;
      waitrequest_r <= 1'b1;
    end else begin
      for (int n = 0; n < puec_pkg::NUM_CTR; n++) begin
        ctl_r[n] <= ctl_nxt[n];
      end
      filt_r <= filt_nxt;
      readdata_r <= readdata_nxt;
      waitrequest_r <= waitrequest_nxt;
    end
  end

  assign o_readdata = readdata_r;
  assign o_waitrequest = waitrequest_r;

  // ****************************************
  // Counter channels
  // ****************************************
  // Every channel gets the full event mux, so any code runs on any counter
  for (genvar g = 0; g < puec_pkg::NUM_CTR; g++) begin : g_ctr
    puec_event_select u_sel (
      .i_cond(i_cond),
      .i_core_trans_any(core_trans_any),
      .i_evt(ctl_r[g].evt),
      .i_filt(filt_r),
      .o_hit(hit[g]),
      .o_defined(defined[g])
    );

    puec_counter u_cnt (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_ctl(ctl_r[g]),
      .i_hit(hit[g]),
      .i_defined(defined[g]),
      .i_clear(clear[g]),
      .i_load_lo(load_lo[g]),
      .i_load_hi(load_hi[g]),
      .i_wdata(cnt_wdata[g]),
      .o_count(count[g])
    );
  end

endmodule // puec_top

// ===== tb/puec_cond_model.sv
`timescale 1ns/1ps
module puec_cond_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Wanted state
  input wire puec_pkg::puec_cond_type i_goal,
  input wire logic [7:0] i_core_goal,
  // Conditions out
  output puec_pkg::puec_cond_type o_cond,
  output logic [7:0] o_core_trans
);
  // ****
  // State settling
  // ****
  puec_pkg::puec_cond_type cond_nxt;
  always_comb begin
    cond_nxt = i_goal;
    // A state change spends a cycle unsettled
    cond_nxt.pkg_settled = (i_goal.pkg_cstate == o_cond.pkg_cstate);
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cond <= '0;
      o_core_trans <= 8'h00;
    end else begin
      o_cond <= cond_nxt;
      o_core_trans <= i_core_goal;
    end
  end
endmodule // puec_cond_model

// ===== tb/puec_monitor.sv
`timescale 1ns/1ps
module puec_monitor #(
  parameter int NUM_CORES = 8
) (
  // Bus
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [puec_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // Conditions
  input wire puec_pkg::puec_cond_type i_cond,
  input wire logic [NUM_CORES-1:0] i_core_trans
);
  // ****
  // Port checks
  // ****
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  logic rd_acc;
  logic st_acc;
  assign rd_acc = i_read && o_waitrequest;
  assign st_acc = rd_acc && i_address == puec_pkg::OFS_STATUS;
  wait_once_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bad wait");
  wait_cause_a: assert property (!o_waitrequest |-> $past(o_waitrequest) && ($past(i_read) || $past(i_write)))
    else $error("stray answer");
  read_hold_a: assert property (!rd_acc |=> $stable(o_readdata))
    else $error("readdata moved");
  unmapped_zero_a: assert property (rd_acc && i_address >= 8'h38 |=> o_readdata == 32'h0)
    else $error("unmapped not zero");
  status_flags_a: assert property (
    st_acc |=> o_readdata[1:0] == {$past(i_cond.mem_phase_shed), $past(i_cond.freq_changing)})
    else $error("bad status flags");
  status_heat_a: assert property (
    st_acc |=> o_readdata[3:2] == {$past(i_cond.prochot_int), $past(i_cond.prochot_ext)})
    else $error("bad throttle flags");
  status_state_a: assert property (
    st_acc |=> o_readdata[6:4] == {$past(i_cond.pkg_settled), $past(i_cond.pkg_cstate)})
    else $error("bad package state");
  status_trans_a: assert property (st_acc |=> o_readdata[7] == |$past(i_core_trans))
    else $error("bad transition flag");
endmodule // puec_monitor
bind puec_top puec_monitor #(.NUM_CORES(NUM_CORES)) u_mon (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_address(i_address), .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .i_cond(i_cond), .i_core_trans(i_core_trans));

// ===== tb/power_unit_event_counter_select_bench.sv
`timescale 1ns/1ps
module power_unit_event_counter_select_bench;
  logic i_clock;
  logic i_rst_n = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  puec_pkg::puec_cond_type goal = '0;
  puec_pkg::puec_cond_type cond;
  logic [7:0] core_goal = 8'h00;
  logic [7:0] trans;
  puec_pkg::puec_ctl_type ctl_s [4];
  logic [3:0] filt_s;
  logic [47:0] cnt_s [4];
  logic [3:0] prev_s;
  logic [31:0] exp_rd;
  logic [31:0] seed = 32'h50;
  logic [31:0] rv;
  logic [1:0] s;
  logic q;
  logic [3:0] be = 4'hF;
  logic [31:0] wd;
  logic [1:0] ci;
  int checks = 0;
  int n_fail = 0;
  logic [7:0] codes [11] = '{8'h00, 8'h09, 8'h0A, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2F, 8'h72, 8'h74, 8'h33};
  puec_top #(.NUM_CORES(8)) u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_byteenable(be), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_cond(cond), .i_core_trans(trans));
  puec_cond_model u_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_goal(goal), .i_core_goal(core_goal),
    .o_cond(cond), .o_core_trans(trans));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // ****
  // Expected behaviour
  // ****
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [1:0] sel(input logic [7:0] e);
    case (e)
      8'h00: sel = 2'b11;
      8'h09: sel = {1'b1, cond.prochot_int};
      8'h0A: sel = {1'b1, cond.prochot_ext};
      8'h2A, 8'h2B, 8'h2C, 8'h2D: sel = {1'b1, cond.pkg_settled && cond.pkg_cstate == e[1:0] - 2'h2};
      8'h2F: sel = {1'b1, cond.mem_phase_shed};
      8'h72: sel = {1'b1, |trans};
      8'h74: sel = {1'b1, cond.freq_changing};
      default: sel = 2'b00;
    endcase
    if (filt_s[3] && e != 8'h00 && e != 8'h74) sel[0] = sel[0] && cond.thread_mask[filt_s[2:0]];
  endfunction
  // Only the enabled byte lanes of a write replace the register's current word
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
    for (int i = 0; i < 4; i++) if (b[i]) o[i*8 +: 8] = d[i*8 +: 8];
    return o;
  endfunction
  function automatic logic [31:0] rdm(input logic [7:0] a);
    logic [47:0] c;
    c = cnt_s[{a[5], a[3]}];
    if (a >= 8'h38) return 32'h0;
    if (a < 8'h10) return {8'h00, ctl_s[a[3:2]].inv, ctl_s[a[3:2]].en, 3'h0, ctl_s[a[3:2]].edge_det, 10'h000,
      ctl_s[a[3:2]].evt};
    if (a == 8'h30) return {23'h0, filt_s[3], 5'h00, filt_s[2:0]};
    if (a == 8'h34) return {16'h0, cond.thread_mask, |trans, cond.pkg_settled, cond.pkg_cstate,
      cond.prochot_int, cond.prochot_ext, cond.mem_phase_shed, cond.freq_changing};
    return a[2] ? {16'h0, c[47:32]} : c[31:0];
  endfunction
  always @(posedge i_clock) begin
    rv = xs();
    goal <= {rv[3:0], ((rv[7:4] == 4'h0) ? rv[9:8] : goal.pkg_cstate), 1'b0, rv[17:10]};
    core_goal <= rv[25:18] & rv[31:24];
  end
  // Shadow counters follow the same edges the bus master sees
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctl_s <= '{default: '0};
      cnt_s <= '{default: '0};
      filt_s <= 4'h0;
      prev_s <= 4'h0;
    end else begin
      if (i_read && o_waitrequest) exp_rd <= rdm(i_address);
      for (int n = 0; n < 4; n++) begin
        s = sel(ctl_s[n].evt);
        q = s[0] ^ ctl_s[n].inv;
        if (ctl_s[n].en && s[1] && q && !(ctl_s[n].edge_det && prev_s[n])) cnt_s[n] <= cnt_s[n] + 48'h1;
        prev_s[n] <= q;
      end
      // A software write sets the whole next shadow counter, keeping the old other half, so it wins over the count above
      if (i_write && !o_waitrequest) begin
        wd = bmerge(rdm(i_address), i_writedata, be);
        ci = {i_address[5], i_address[3]};
        if (i_address < 8'h10) begin
          ctl_s[i_address[3:2]] <= {wd[23:22], wd[18], wd[7:0]};
          if (wd[17]) cnt_s[i_address[3:2]] <= 48'h0;
        end
        if (i_address >= 8'h10 && i_address < 8'h30)
          cnt_s[ci] <= i_address[2] ? {wd[15:0], cnt_s[ci][31:0]} : {cnt_s[ci][47:32], wd};
        if (i_address == 8'h30) filt_s <= {wd[8], wd[2:0]};
      end
    end
  end
  // ****
  // Bus and checking
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= d;
    i_read <= !w;
    i_write <= w;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 20);
    if (o_waitrequest !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    check(o_readdata, exp_rd);
  endtask
  // Level, entry, exit and filtered rounds over every code and counter
  initial begin
    logic [7:0] a;
    logic [31:0] cfg;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 8'h30, {23'h0, r == 3, 5'h00, 3'(r + 5)});
      for (int k = 0; k < 11; k++) begin
        a = 8'(k % 4) << 2;
        cfg = {8'h00, r == 2, 1'b0, 3'h0, r == 1 || r == 2, 1'b1, 9'h000, codes[k]};
        bus(1'b1, a, cfg);
        cfg[22] = 1'b1;
        bus(1'b1, a, cfg);
        repeat (40) @(posedge i_clock);
        rd(8'h10 + a + a);
        rd(8'h14 + a + a);
        rd(8'h34);
        rd(8'hFC - a);
      end
    end
    // Corner cases: carry into the high word, partial lanes, read-back and a mid-run reset
    bus(1'b1, 8'h00, 32'h0040_0000);
    bus(1'b1, 8'h14, 32'h0000_A5C3);
    bus(1'b1, 8'h10, 32'hFFFF_FFF0);
    repeat (30) @(posedge i_clock);
    rd(8'h10);
    rd(8'h14);
    be <= 4'h1;
    bus(1'b1, 8'h04, 32'hFFFF_FF2D);
    rd(8'h04);
    be <= 4'h4;
    bus(1'b1, 8'h04, 32'h0006_0000);
    rd(8'h04);
    rd(8'h1C);
    be <= 4'hF;
    rd(8'h30);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    check({31'h0, o_waitrequest}, 32'h0000_0001);
    check(o_readdata, 32'h0000_0000);
    i_rst_n <= 1'b1;
    rd(8'h10);
    rd(8'h00);
    report_and_stop();
  end
endmodule // power_unit_event_counter_select_bench
